// ===== rtl/lpm_consts.vh
// Constants of the LED charge-pump mode and gain controller.
// Assumes a 40 MHz system clock and 8-bit register addresses.
`ifndef LPM_CONSTS_VH
`define LPM_CONSTS_VH

// ****************************************
// Timing
// ****************************************
`define LPM_CLK_PERIOD_NS   25
`define LPM_SETTLE_NS       100000
`define LPM_RST_FILTER_NS   50000
`define LPM_CNT_W           12

// ****************************************
// Register offsets
// ****************************************
`define LPM_ADDR_STATUS     8'h00
`define LPM_ADDR_MODE       8'h01
`define LPM_ADDR_LEVEL      8'h04
`define LPM_ADDR_SINK_EN    8'h05
`define LPM_ADDR_DAY_MAX    8'h09
`define LPM_ADDR_DAY_DIM    8'h0a
`define LPM_ADDR_OFF_MAX    8'h0b
`define LPM_ADDR_OFF_DIM    8'h0c
`define LPM_ADDR_DARK_MAX   8'h0d
`define LPM_ADDR_DARK_DIM   8'h0e

// ****************************************
// Field positions
// ****************************************
`define LPM_MODE_STBY_BIT   0
`define LPM_MODE_AUTO_BIT   1
`define LPM_LEVEL_LSB       0
`define LPM_LEVEL_MSB       1
`define LPM_BRIGHT_MSB      6

// ****************************************
// Brightness level codes
// ****************************************
`define LPM_LVL_DAY         2'h0
`define LPM_LVL_OFFICE      2'h1
`define LPM_LVL_DARK        2'h2

// ****************************************
// Reset values
// ****************************************
`define LPM_RST_MODE        8'h00
`define LPM_RST_LEVEL       8'h00
`define LPM_RST_SINK_EN     8'h7f
`define LPM_RST_BRIGHT      8'h00

`endif

// ===== rtl/lpm_ctrl.v
// Mode, pump gain and brightness-level control of a charge-pump LED driver.
// Registers arrive as decoded serial-bus byte accesses; the analog pump,
// headroom comparators and ambient light logic sit outside.
`timescale 1ns/1ps
`include "lpm_consts.vh"

// Operation
// R1 - Start-up puts the pump in unity gain before any gain increase.
// R2 - Any enabled sink below 200 mV headroom steps gain up one level.
// R3 - Wait 100 us settling after each gain change before deciding again.
// R4 - Lower gain when all sinks exceed the internal upper headroom threshold.
// R5 - Only enabled sinks take part in gain decisions.
// R6 - Unity connects input directly; 1.5x charges series, discharges parallel.
// R7 - 2x charges both capacitors in parallel, discharges parallel, alternating.
// R8 - Faults open every pump switch, isolating output from input.
// R9 - Soft start runs after lockout release, fault or standby recovery.
// R10 - Soft start done enters unity gain, then automatic gain selection.
// R11 - Standby-release bit set to 1 puts the device in active mode.
// R12 - Standby when release bit is 0 or reset pin low too long.
// R13 - Leaving shutdown resets all registers and lands in standby.
// R14 - Reset pin low holds standby, defaults, and no acknowledge.
// R15 - After reset pin release, defaults stay, standby stays, accesses acknowledged.
// R16 - Reset pin passes a 50 us filter; must stay low throughout.
// R17 - Level 00 uses daylight max 0x09 and dim 0x0a.
// R18 - Level 01 uses office max 0x0b and dim 0x0c.
// R19 - Level 10 uses dark max 0x0d and dim 0x0e.
// R20 - Host writes level; ambient logic updates it when auto enable set.
// R21 - Maximum and dim settings are 7-bit codes, 128 levels.
// R22 - Gain reductions also step once and respect the settling interval.
module lpm_ctrl #(
	parameter SINKS = 7
) (
	input  wire             clk_in,
	input  wire             sys_rst_in,
	input  wire             clk_en_in,
	input  wire             undervoltage_lockout_in,
	input  wire             fault_in,
	input  wire             hw_reset_low_pin_in,
	input  wire             ss_reached_in,
	input  wire [SINKS-1:0] sink_low_hr_in,
	input  wire [SINKS-1:0] sink_high_hr_in,
	input  wire [1:0]       ambient_level_in,
	input  wire             reg_wr_in,
	input  wire             reg_rd_in,
	input  wire [7:0]       reg_addr_in,
	input  wire [7:0]       reg_wdata_in,
	output reg  [7:0]       reg_rdata_out,
	output reg              reg_ack_out,
	output reg              active_out,
	output reg              soft_start_out,
	output reg  [2:0]       gain_out,
	output reg              sw_direct_out,
	output reg              sw_chg_series_out,
	output reg              sw_chg_parallel_out,
	output reg              sw_dis_parallel_out,
	output reg  [6:0]       bl_max_out,
	output reg  [6:0]       bl_dim_out
);

	// ****************************************
	// Timing counts
	// ****************************************
	localparam integer SETTLE_RAW =
		(`LPM_SETTLE_NS + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS;
	localparam integer FILTER_RAW =
		(`LPM_RST_FILTER_NS + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS;
	// Cut to the counter width on purpose; both counts fit in it
	localparam [`LPM_CNT_W-1:0] SETTLE_CYC = SETTLE_RAW[`LPM_CNT_W-1:0];
	localparam [`LPM_CNT_W-1:0] FILTER_CYC = FILTER_RAW[`LPM_CNT_W-1:0];

	// ****************************************
	// Pump states, one-hot
	// ****************************************
	localparam [4:0] ST_OFF = 5'h01;
	localparam [4:0] ST_SS  = 5'h02;
	localparam [4:0] ST_G1  = 5'h04;
	localparam [4:0] ST_G15 = 5'h08;
	localparam [4:0] ST_G2  = 5'h10;

	// ****************************************
	// Register decode
	// ****************************************
	function [7:0] addr_sel;
		input [7:0] addr;
		begin
			case (addr)
				`LPM_ADDR_MODE:     addr_sel = 8'h01;
				`LPM_ADDR_LEVEL:    addr_sel = 8'h02;
				`LPM_ADDR_SINK_EN:  addr_sel = 8'h04;
				`LPM_ADDR_DAY_MAX:  addr_sel = 8'h08;
				`LPM_ADDR_DAY_DIM:  addr_sel = 8'h10;
				`LPM_ADDR_OFF_MAX:  addr_sel = 8'h20;
				`LPM_ADDR_OFF_DIM:  addr_sel = 8'h40;
				`LPM_ADDR_DARK_MAX: addr_sel = 8'h80;
				default:            addr_sel = 8'h00;
			endcase
		end
	endfunction

	// ****************************************
	// Brightness level pick
	// ****************************************
	function [`LPM_BRIGHT_MSB:0] level_pick;
		input [1:0] lvl;
		input [7:0] day;
		input [7:0] office;
		input [7:0] dark;
		begin
			case (lvl)
				`LPM_LVL_OFFICE: level_pick = office[`LPM_BRIGHT_MSB:0]; // R18 R21
				`LPM_LVL_DARK:   level_pick = dark[`LPM_BRIGHT_MSB:0]; // R19 R21
				default:         level_pick = day[`LPM_BRIGHT_MSB:0]; // R17 R21
			endcase
		end
	endfunction

	// ****************************************
	// State
	// ****************************************
	reg  [7:0]            mode_control_reg_r;
	reg  [7:0]            level_cfg_r;
	reg  [7:0]            sink_en_r;
	reg  [7:0]            day_max_r;
	reg  [7:0]            day_dim_r;
	reg  [7:0]            off_max_r;
	reg  [7:0]            off_dim_r;
	reg  [7:0]            dark_max_r;
	reg  [7:0]            dark_dim_r;
	reg  [`LPM_CNT_W-1:0] filt_cnt_r;
	reg                   rst_filt_r;
	reg  [`LPM_CNT_W-1:0] settle_cnt_r;
	reg  [`LPM_CNT_W-1:0] settle_cnt_nxt;
	reg  [4:0]            state_r;
	reg  [4:0]            state_nxt;
	reg                   phase_r;

	wire       reg_clr;
	wire       standby_release_bit;
	wire       ambient_auto_level_enable;
	wire [1:0] brightness_level_select;
	wire       go_active;
	wire       any_low;
	wire       all_high;
	wire [7:0] wsel;
	wire       acc_ok;
	wire       settled;
	wire       pumping;

	// Shutdown exit or a filtered reset pin returns every register to default
	assign reg_clr = sys_rst_in | (clk_en_in & (undervoltage_lockout_in | rst_filt_r)); // R13 R14
	assign standby_release_bit = mode_control_reg_r[`LPM_MODE_STBY_BIT];
	assign ambient_auto_level_enable = mode_control_reg_r[`LPM_MODE_AUTO_BIT];
	assign brightness_level_select = level_cfg_r[`LPM_LEVEL_MSB:`LPM_LEVEL_LSB];
	assign go_active = standby_release_bit & ~rst_filt_r & ~undervoltage_lockout_in; // R11 R12
	assign any_low  = |(sink_low_hr_in & sink_en_r[SINKS-1:0]); // R2 R5
	assign all_high = &(sink_high_hr_in | ~sink_en_r[SINKS-1:0]); // R4 R5
	assign acc_ok = ~rst_filt_r; // R14 R15
	assign wsel = (reg_wr_in & acc_ok) ? addr_sel(reg_addr_in) : 8'h00;
	assign settled = (settle_cnt_r == {`LPM_CNT_W{1'b0}}); // R3 R22
	// Charge and discharge phases alternate only in the boosting gains
	assign pumping = state_nxt[3] | state_nxt[4]; // R6 R7

	// ****************************************
	// Reset pin noise filter
	// ****************************************
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			filt_cnt_r <= {`LPM_CNT_W{1'b0}};
			rst_filt_r <= 1'b0;
		end else if (clk_en_in) begin
			if (hw_reset_low_pin_in) begin
				filt_cnt_r <= {`LPM_CNT_W{1'b0}}; // R16
				rst_filt_r <= 1'b0; // R15
			end else if (filt_cnt_r != FILTER_CYC) begin
				filt_cnt_r <= filt_cnt_r + 1'b1;
			end else begin
				rst_filt_r <= 1'b1; // R16 R12
			end
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	always @(posedge clk_in) begin
		if (reg_clr) begin
			mode_control_reg_r <= `LPM_RST_MODE;
			level_cfg_r        <= `LPM_RST_LEVEL;
			sink_en_r          <= `LPM_RST_SINK_EN;
			day_max_r          <= `LPM_RST_BRIGHT;
			day_dim_r          <= `LPM_RST_BRIGHT;
			off_max_r          <= `LPM_RST_BRIGHT;
			off_dim_r          <= `LPM_RST_BRIGHT;
			dark_max_r         <= `LPM_RST_BRIGHT;
			dark_dim_r         <= `LPM_RST_BRIGHT;
		end else if (clk_en_in) begin
			if (wsel[0]) begin
				mode_control_reg_r <= reg_wdata_in;
			end
			if (ambient_auto_level_enable) begin
				level_cfg_r[`LPM_LEVEL_MSB:`LPM_LEVEL_LSB] <= ambient_level_in; // R20
			end else if (wsel[1]) begin
				level_cfg_r <= reg_wdata_in; // R20
			end
			if (wsel[2]) begin
				sink_en_r <= reg_wdata_in; // R5
			end
			if (wsel[3]) begin
				day_max_r <= reg_wdata_in;
			end
			if (wsel[4]) begin
				day_dim_r <= reg_wdata_in;
			end
			if (wsel[5]) begin
				off_max_r <= reg_wdata_in;
			end
			if (wsel[6]) begin
				off_dim_r <= reg_wdata_in;
			end
			if (wsel[7]) begin
				dark_max_r <= reg_wdata_in;
			end
			if (reg_wr_in & acc_ok & (reg_addr_in == `LPM_ADDR_DARK_DIM)) begin
				dark_dim_r <= reg_wdata_in;
			end
		end
	end

	// ****************************************
	// Pump state machine
	// ****************************************
	always @* begin
		state_nxt = state_r;
		settle_cnt_nxt = (settle_cnt_r != {`LPM_CNT_W{1'b0}}) ?
			settle_cnt_r - 1'b1 : settle_cnt_r;
		case (state_r)
			ST_OFF: begin
				if (go_active & ~fault_in) begin
					state_nxt = ST_SS; // R9
				end
			end
			ST_SS: begin
				if (ss_reached_in) begin
					state_nxt = ST_G1; // R1 R10
					settle_cnt_nxt = SETTLE_CYC; // R3
				end
			end
			ST_G1: begin
				if (settled && any_low) begin
					state_nxt = ST_G15; // R2
					settle_cnt_nxt = SETTLE_CYC; // R3
				end
			end
			ST_G15: begin
				if (settled) begin
					if (any_low) begin
						state_nxt = ST_G2; // R2
						settle_cnt_nxt = SETTLE_CYC; // R3
					end else if (all_high) begin
						state_nxt = ST_G1; // R4 R22
						settle_cnt_nxt = SETTLE_CYC; // R22
					end
				end
			end
			ST_G2: begin
				if (settled && all_high && ~any_low) begin
					state_nxt = ST_G15; // R4 R22
					settle_cnt_nxt = SETTLE_CYC; // R22
				end
			end
			default: begin
				state_nxt = ST_OFF;
			end
		endcase
		// Standby, shutdown or fault drops to isolation from any state
		if (~go_active | fault_in) begin
			state_nxt = ST_OFF; // R8 R12
			settle_cnt_nxt = {`LPM_CNT_W{1'b0}};
		end
	end

	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_r      <= ST_OFF;
			settle_cnt_r <= {`LPM_CNT_W{1'b0}};
			phase_r      <= 1'b0;
		end else if (clk_en_in) begin
			state_r      <= state_nxt;
			settle_cnt_r <= settle_cnt_nxt;
			phase_r      <= ~phase_r & pumping; // R7
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			reg_rdata_out       <= 8'h00;
			reg_ack_out         <= 1'b0;
			active_out          <= 1'b0;
			soft_start_out      <= 1'b0;
			gain_out            <= 3'h0;
			sw_direct_out       <= 1'b0;
			sw_chg_series_out   <= 1'b0;
			sw_chg_parallel_out <= 1'b0;
			sw_dis_parallel_out <= 1'b0;
			bl_max_out          <= 7'h00;
			bl_dim_out          <= 7'h00;
		end else if (clk_en_in) begin
			reg_ack_out <= (reg_wr_in | reg_rd_in) & acc_ok; // R14 R15
			if (reg_rd_in & acc_ok) begin
				case (reg_addr_in)
					`LPM_ADDR_STATUS:   reg_rdata_out <= {go_active, state_r, 2'h0};
					`LPM_ADDR_MODE:     reg_rdata_out <= mode_control_reg_r;
					`LPM_ADDR_LEVEL:    reg_rdata_out <= level_cfg_r;
					`LPM_ADDR_SINK_EN:  reg_rdata_out <= sink_en_r;
					`LPM_ADDR_DAY_MAX:  reg_rdata_out <= day_max_r;
					`LPM_ADDR_DAY_DIM:  reg_rdata_out <= day_dim_r;
					`LPM_ADDR_OFF_MAX:  reg_rdata_out <= off_max_r;
					`LPM_ADDR_OFF_DIM:  reg_rdata_out <= off_dim_r;
					`LPM_ADDR_DARK_MAX: reg_rdata_out <= dark_max_r;
					`LPM_ADDR_DARK_DIM: reg_rdata_out <= dark_dim_r;
					default:            reg_rdata_out <= 8'h00;
				endcase
			end else begin
				reg_rdata_out <= 8'h00;
			end
			active_out     <= go_active; // R11
			soft_start_out <= state_nxt[1]; // R9
			gain_out       <= state_nxt[4:2];
			// Switch network per gain and phase; all open when off or soft start
			sw_direct_out       <= state_nxt[2]; // R6 R8
			sw_chg_series_out   <= state_nxt[3] & ~phase_r; // R6
			sw_chg_parallel_out <= state_nxt[4] & ~phase_r; // R7
			sw_dis_parallel_out <= pumping & phase_r; // R6 R7
			bl_max_out <= level_pick(brightness_level_select,
				day_max_r, off_max_r, dark_max_r); // R17 R18 R19 R21
			bl_dim_out <= level_pick(brightness_level_select,
				day_dim_r, off_dim_r, dark_dim_r); // R17 R18 R19
		end
	end

endmodule // lpm_ctrl

// ===== test/lpm_ctrl_asserts.sv
// Port checker of the pump mode and gain controller.
// Sees only the lpm_ctrl ports; bound at the foot.
`timescale 1ns/1ps
// *******
// Checker
// *******
module lpm_ctrl_asserts (
	input logic       clk_in,
	input logic       sys_rst_in,
	input logic       clk_en_in,
	input logic       fault_in,
	input logic       hw_reset_low_pin_in,
	input logic       reg_ack_out,
	input logic       active_out,
	input logic       soft_start_out,
	input logic [2:0] gain_out,
	input logic       sw_direct_out,
	input logic       sw_chg_series_out,
	input logic       sw_chg_parallel_out,
	input logic       sw_dis_parallel_out
);
	logic [11:0] hold_r;
	logic [11:0] low_r;
	logic [2:0]  prev_r;
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// Cycles the shown gain has stood; cycles the pin has been low
	always @(posedge clk_in) begin
		prev_r <= gain_out;
		hold_r <= (sys_rst_in || gain_out != prev_r) ? 12'h1 : hold_r + {11'h0, ~&hold_r};
		low_r  <= hw_reset_low_pin_in ? 12'h0 : low_r + {11'h0, clk_en_in & ~&low_r};
	end
	sequence gain_moved;
		$past(gain_out) != 3'h0 && gain_out != 3'h0 && gain_out != $past(gain_out);
	endsequence
	sequence phase_held(logic [2:0] g);
		$past(clk_en_in) && $past(gain_out) == g && gain_out == g;
	endsequence
	unity_first_a: assert property (
		gain_out != 3'h0 && $past(gain_out) == 3'h0 |-> gain_out == 3'h1 && $past(soft_start_out))
		else $error("pump left off not into unity");
	one_step_a: assert property (
		gain_moved |-> gain_out == $past(gain_out) << 1 || gain_out == $past(gain_out) >> 1)
		else $error("gain jumped");
	settle_hold_a: assert property (
		gain_moved |-> hold_r >= 12'd4000)
		else $error("gain changed too soon");
	direct_path_a: assert property (
		gain_out == 3'h1 |-> sw_direct_out && !sw_chg_series_out && !sw_chg_parallel_out
			&& !sw_dis_parallel_out)
		else $error("unity switch set wrong");
	half_gain_a: assert property (
		phase_held(3'h2) |-> sw_chg_series_out != $past(sw_chg_series_out)
			&& sw_dis_parallel_out == !sw_chg_series_out && !sw_chg_parallel_out)
		else $error("half gain phases wrong");
	double_gain_a: assert property (
		phase_held(3'h4) |-> sw_chg_parallel_out != $past(sw_chg_parallel_out)
			&& sw_dis_parallel_out == !sw_chg_parallel_out && !sw_chg_series_out)
		else $error("double gain phases wrong");
	fault_open_a: assert property (
		(fault_in && clk_en_in) [*3] |-> {gain_out, soft_start_out, sw_direct_out,
			sw_chg_series_out, sw_chg_parallel_out, sw_dis_parallel_out} == 8'h0)
		else $error("switches closed in fault");
	pin_reset_a: assert property (
		low_r >= 12'd2003 |-> !active_out && !reg_ack_out && gain_out == 3'h0)
		else $error("pin reset not obeyed");
endmodule // lpm_ctrl_asserts

bind lpm_ctrl lpm_ctrl_asserts chk_inst (.clk_in, .sys_rst_in, .clk_en_in, .fault_in,
	.hw_reset_low_pin_in, .reg_ack_out, .active_out, .soft_start_out, .gain_out,
	.sw_direct_out, .sw_chg_series_out, .sw_chg_parallel_out, .sw_dis_parallel_out);

// ===== test/lpm_host_model.sv
// Host model: byte register accesses and the reset pin.
// Strobes last one cycle; idle bus lines show inverted data.
`timescale 1ns/1ps
// **********
// Host model
// **********
module lpm_host_model (
	input  logic       clk_in,
	input  logic       reg_ack_out,
	input  logic [7:0] reg_rdata_out,
	output logic       reg_wr_in,
	output logic       reg_rd_in,
	output logic [7:0] reg_addr_in,
	output logic [7:0] reg_wdata_in,
	output logic       hw_reset_low_pin_in
);
	initial {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, hw_reset_low_pin_in} = 19'h1;
	// Returns {ack, read data}
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [8:0] r);
		@(posedge clk_in);
		#1 reg_wr_in = w;
		reg_rd_in = !w;
		reg_addr_in = a;
		reg_wdata_in = d;
		@(posedge clk_in);
		#1 reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		reg_addr_in = ~a;
		reg_wdata_in = ~d;
		r = {reg_ack_out, reg_rdata_out};
	endtask
	task pin_low(input int n);
		@(posedge clk_in);
		#1 hw_reset_low_pin_in = 1'b0;
		repeat (n) @(posedge clk_in);
		#1 hw_reset_low_pin_in = 1'b1;
	endtask
endmodule // lpm_host_model

// ===== test/tb.sv
// Bench of lpm_ctrl: registers, levels, gain steps, fault, resets.
// Uses lpm_host_model for the bus and pin; checker is bound.
`timescale 1ns/1ps
module tb;
	logic        clk_in, sys_rst_in, clk_en_in, undervoltage_lockout_in, fault_in, ss_reached_in;
	logic        reg_wr_in, reg_rd_in, hw_reset_low_pin_in, reg_ack_out, active_out;
	logic        soft_start_out, sw_direct_out, sw_chg_series_out;
	logic        sw_chg_parallel_out, sw_dis_parallel_out;
	logic [6:0]  sink_low_hr_in, sink_high_hr_in, bl_max_out, bl_dim_out;
	logic [1:0]  ambient_level_in;
	logic [2:0]  gain_out;
	logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
	logic [8:0]  r;
	int          err_count, num_checks, i;
	logic [15:0] rows [4] = '{{2'h0, 7'h11, 7'h12}, {2'h1, 7'h23, 7'h34},
		{2'h2, 7'h45, 7'h56}, {2'h3, 7'h11, 7'h12}};
	lpm_ctrl lpm_ctrl_inst (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
		.undervoltage_lockout_in(undervoltage_lockout_in), .fault_in(fault_in),
		.hw_reset_low_pin_in(hw_reset_low_pin_in), .ss_reached_in(ss_reached_in),
		.sink_low_hr_in(sink_low_hr_in), .sink_high_hr_in(sink_high_hr_in),
		.ambient_level_in(ambient_level_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
		.active_out(active_out), .soft_start_out(soft_start_out), .gain_out(gain_out),
		.sw_direct_out(sw_direct_out), .sw_chg_series_out(sw_chg_series_out),
		.sw_chg_parallel_out(sw_chg_parallel_out),
		.sw_dis_parallel_out(sw_dis_parallel_out),
		.bl_max_out(bl_max_out), .bl_dim_out(bl_dim_out));
	lpm_host_model h (
		.clk_in(clk_in), .reg_ack_out(reg_ack_out), .reg_rdata_out(reg_rdata_out),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .hw_reset_low_pin_in(hw_reset_low_pin_in));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task stop_test;
		$display("checks %0d, errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	initial begin
		#1000000;
		err_count++;
		stop_test;
	end
	initial begin
		{sys_rst_in, clk_en_in, undervoltage_lockout_in, fault_in, ss_reached_in} = 5'h18;
		{sink_low_hr_in, sink_high_hr_in, ambient_level_in} = 16'h0;
		cyc(4);
		sys_rst_in = 1'b0;
		cyc(1);
		chk({active_out, soft_start_out, gain_out, bl_max_out}, 16'h0);
		h.acc(1'b0, 8'h05, 8'h00, r);
		chk(r, 9'h17f);
		for (i = 0; i < 3; i++) begin
			h.acc(1'b1, 8'h09 + 8'(2 * i), {1'b1, rows[i][13:7]}, r);
			h.acc(1'b1, 8'h0a + 8'(2 * i), {1'b0, rows[i][6:0]}, r);
			h.acc(1'b0, 8'h09 + 8'(2 * i), 8'h00, r);
			chk(r, {2'h3, rows[i][13:7]});
		end
		for (i = 0; i < 4; i++) begin
			h.acc(1'b1, 8'h04, {6'h00, rows[i][15:14]}, r);
			cyc(2);
			chk({bl_max_out, bl_dim_out}, rows[i][13:0]);
		end
		h.acc(1'b0, 8'h3f, 8'h00, r);
		chk(r, 9'h100);
		ambient_level_in = 2'h2;
		h.acc(1'b1, 8'h01, 8'h02, r);
		h.acc(1'b1, 8'h04, 8'h01, r);
		cyc(2);
		chk({bl_max_out, bl_dim_out}, rows[2][13:0]);
		h.acc(1'b1, 8'h05, 8'h7e, r);
		sink_low_hr_in = 7'h01;
		h.acc(1'b1, 8'h01, 8'h01, r);
		cyc(4);
		chk({active_out, soft_start_out, gain_out}, 5'h18);
		ss_reached_in = 1'b1;
		cyc(2);
		chk(gain_out, 3'h1);
		cyc(4100);
		chk(gain_out, 3'h1);
		sink_low_hr_in = 7'h02;
		cyc(10);
		chk(gain_out, 3'h2);
		cyc(3900);
		chk(gain_out, 3'h2);
		cyc(200);
		chk(gain_out, 3'h4);
		sink_low_hr_in = 7'h00;
		sink_high_hr_in = 7'h7e;
		cyc(3880);
		chk(gain_out, 3'h4);
		cyc(20);
		chk(gain_out, 3'h2);
		cyc(4100);
		chk(gain_out, 3'h1);
		fault_in = 1'b1;
		ss_reached_in = 1'b0;
		cyc(4);
		chk({gain_out, sw_direct_out, soft_start_out}, 5'h0);
		fault_in = 1'b0;
		cyc(4);
		chk(soft_start_out, 1'b1);
		h.acc(1'b1, 8'h01, 8'h00, r);
		cyc(3);
		chk({active_out, soft_start_out, gain_out}, 5'h0);
		h.pin_low(1000);
		h.acc(1'b0, 8'h04, 8'h00, r);
		chk(r, 9'h102);
		fork
			h.pin_low(2100);
			begin
				cyc(2050);
				h.acc(1'b0, 8'h04, 8'h00, r);
				chk(r, 9'h000);
			end
		join
		h.acc(1'b0, 8'h04, 8'h00, r);
		chk({active_out, r}, 10'h100);
		h.acc(1'b1, 8'h04, 8'h01, r);
		undervoltage_lockout_in = 1'b1;
		cyc(3);
		undervoltage_lockout_in = 1'b0;
		h.acc(1'b0, 8'h04, 8'h00, r);
		chk(r, 9'h100);
		stop_test;
	end
endmodule // tb
